/* File: rtl/eimu_pkg.sv */
/*
 * constants for the upper event interrupt mask block: register indices,
 * field positions, reset values and error cause layout.
 * assumes a 32-bit register bus where byte address = 4 * index.
 */
package eimu_pkg;

	// ---------------------------------------------------------------
	// register indices
	// ---------------------------------------------------------------
	localparam int unsigned IDX_W        = 6;
	localparam logic [5:0]  MASK_IDX     = 6'h0e;
	localparam logic [5:0]  STATUS_IDX   = 6'h0f;
	localparam logic [5:0]  ERR_STAT_IDX = 6'h10;
	localparam logic [5:0]  ERR_MASK_IDX = 6'h11;

	// ---------------------------------------------------------------
	// event field positions
	// ---------------------------------------------------------------
	localparam int unsigned BIT_PEND     = 0;
	localparam int unsigned BIT_PTO      = 21;
	localparam int unsigned BIT_PIN      = 22;
	localparam int unsigned BIT_SLP      = 23;
	localparam int unsigned BIT_RPLL     = 24;
	localparam int unsigned BIT_CPLL     = 25;
	localparam int unsigned BIT_SFDTO    = 26;
	localparam int unsigned BIT_HPW      = 27;
	localparam int unsigned BIT_TX_BUFFER_ERROR_EVENT   = 28;
	localparam int unsigned BIT_FREJ     = 29;
	localparam logic [31:0] EVENT_BITS   = 32'h3fe0_0000;
	localparam logic [31:0] RSVD_BITS    = 32'hc000_0000;

	// ---------------------------------------------------------------
	// reset values and error causes
	// ---------------------------------------------------------------
	localparam logic [31:0] MASK_RST     = 32'h0000_0000;
	localparam logic [31:0] STATUS_RST   = 32'h0000_0000;
	localparam int unsigned ERR_W        = 2;
	localparam logic [1:0]  ERR_RST      = 2'h0;
	localparam int unsigned ERR_UNMAPPED = 0;
	localparam int unsigned ERR_RSVD_WR  = 1;

endpackage

/* File: rtl/eimu_reg_if.sv */
/*
 * carrier between the bus slave and the register core.
 * assumes one clock domain; strobes are one-cycle pulses.
 */
`timescale 1ns/10ps
interface eimu_reg_if;
	logic        wr_stb;
	logic        rd_stb;
	logic [5:0]  idx;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;

	// bus side drives the request, core answers with read data
	modport bus  (output wr_stb, rd_stb, idx, wdata, be, input rdata);
	modport core (input wr_stb, rd_stb, idx, wdata, be, output rdata);
endinterface

/* File: rtl/eimu_sticky.sv */
/*
 * bank of sticky flags: set by hardware, cleared by a clear vector.
 * assumes synchronous active-high reset; set wins over clear.
 */
`timescale 1ns/10ps
module eimu_sticky #(
	parameter int unsigned W = 32
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// set and clear vectors
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	// flag state
	output logic      [W-1:0] q_o
);
	logic [W-1:0] flag_reg;
	logic [W-1:0] flag_next;

	// per-bit latch, an event in the clearing cycle survives
	for (genvar i = 0; i < W; i++) begin : g_bit
		assign flag_next[i] = (flag_reg[i] & ~clr_i[i]) | set_i[i];
	end

	// flag storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign q_o = flag_reg;
endmodule

/* File: rtl/eimu_top.sv */
/*
 * upper event interrupt mask: latched event status, mask, error causes,
 * one level interrupt line, registers on classic wishbone.
 * assumes event inputs are synchronous to clk_i; byte address = 4 * index.
 */
// Chosen here: the Wishbone interface to the registers.
// Behaviour
// - mask bit 21 lets a latched preamble timeout raise the interrupt
// - mask bit 22 lets a latched pin interrupt event raise the interrupt
// - mask bit 23 lets a latched sleep-to-idle event raise the interrupt
// - mask bit 24 lets a radio pll lock loss raise the interrupt
// - a dedicated mask bit lets clock pll lock loss raise the interrupt
// - mask bit 26 lets a frame delimiter timeout raise the interrupt
// - mask bit 27 lets a half period warning raise the interrupt
// - mask bit 28 lets a tx buffer error raise the interrupt
// - mask bit 29 lets a filter reject raise the interrupt
// - mask bits 30 and 31 are reserved and never gate anything
// - interrupt registered: high the cycle after any status bit and its mask are both set
// - status bits latch on events, write one clears, write zero keeps
`timescale 1ns/10ps
module eimu_top
	import eimu_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// event sources
	input  wire logic        preamble_timeout_event_i,
	input  wire logic        pin_interrupt_event_i,
	input  wire logic        sleep_to_idle_event_i,
	input  wire logic        radio_pll_lock_loss_event_i,
	input  wire logic        clock_pll_lock_loss_event_i,
	input  wire logic        frame_delimiter_timeout_event_i,
	input  wire logic        half_period_warning_event_i,
	input  wire logic        tx_buffer_error_event_i,
	input  wire logic        filter_reject_event_i,
	// interrupt request
	output logic             irq_o
);
	// -----------------------------------------------------------------
	// byte lane expansion
	// -----------------------------------------------------------------
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// -----------------------------------------------------------------
	// bus front end
	// -----------------------------------------------------------------
	eimu_reg_if rif ();

	eimu_wb_slave u_bus (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (cyc_i),
		.stb_i (stb_i),
		.we_i  (we_i),
		.adr_i (adr_i),
		.sel_i (sel_i),
		.dat_i (dat_i),
		.dat_o (dat_o),
		.ack_o (ack_o),
		.rif   (rif)
	);

	// -----------------------------------------------------------------
	// address decode
	// -----------------------------------------------------------------
	logic [31:0] wr_lanes;
	logic        hit_mask;
	logic        hit_status;
	logic        hit_err_stat;
	logic        hit_err_mask;
	logic        unmapped;

	// register selects for the current request
	assign wr_lanes     = lane_mask(rif.be);
	assign hit_mask     = (rif.idx == MASK_IDX);
	assign hit_status   = (rif.idx == STATUS_IDX);
	assign hit_err_stat = (rif.idx == ERR_STAT_IDX);
	assign hit_err_mask = (rif.idx == ERR_MASK_IDX);
	assign unmapped     = ~(hit_mask | hit_status | hit_err_stat | hit_err_mask);

	// -----------------------------------------------------------------
	// event mask register
	// -----------------------------------------------------------------
	logic [31:0] mask_reg;
	logic [31:0] mask_next;
	logic [31:0] mask_wm;

	assign mask_wm   = (rif.wr_stb & hit_mask) ? (wr_lanes & EVENT_BITS) : 32'h0000_0000;
	assign mask_next = (mask_reg & ~mask_wm) | (rif.wdata & mask_wm);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_reg <= MASK_RST;
		end else begin
			mask_reg <= mask_next;
		end
	end

	// -----------------------------------------------------------------
	// event status register
	// -----------------------------------------------------------------
	logic [31:0] ev_set;
	logic [31:0] ev_clr;
	logic [31:0] stat_q;

	always_comb begin
		ev_set              = STATUS_RST;
		ev_set[BIT_PTO]     = preamble_timeout_event_i;
		ev_set[BIT_PIN]     = pin_interrupt_event_i;
		ev_set[BIT_SLP]     = sleep_to_idle_event_i;
		ev_set[BIT_RPLL]    = radio_pll_lock_loss_event_i;
		ev_set[BIT_CPLL]    = clock_pll_lock_loss_event_i;
		ev_set[BIT_SFDTO]   = frame_delimiter_timeout_event_i;
		ev_set[BIT_HPW]     = half_period_warning_event_i;
		ev_set[BIT_TX_BUFFER_ERROR_EVENT]  = tx_buffer_error_event_i;
		ev_set[BIT_FREJ]    = filter_reject_event_i;
	end

	assign ev_clr = (rif.wr_stb & hit_status) ? (rif.wdata & wr_lanes & EVENT_BITS)
	                                          : 32'h0000_0000;

	eimu_sticky #(.W(32)) u_status (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.set_i (ev_set),
		.clr_i (ev_clr),
		.q_o   (stat_q)
	);

	// -----------------------------------------------------------------
	// access error causes, cleared by reading them
	// -----------------------------------------------------------------
	logic [ERR_W-1:0] err_set;
	logic [ERR_W-1:0] err_clr;
	logic [ERR_W-1:0] err_q;
	logic [ERR_W-1:0] err_mask_reg;
	logic [ERR_W-1:0] err_mask_next;

	// unmapped access and reserved mask bit writes
	assign err_set[ERR_UNMAPPED] = (rif.wr_stb | rif.rd_stb) & unmapped;
	assign err_set[ERR_RSVD_WR]  = rif.wr_stb & hit_mask & (|(rif.wdata & wr_lanes & RSVD_BITS));
	assign err_clr               = (rif.rd_stb & hit_err_stat) ? {ERR_W{1'b1}} : ERR_RST;
	assign err_mask_next         = (rif.wr_stb & hit_err_mask & rif.be[0]) ?
	                               rif.wdata[ERR_W-1:0] : err_mask_reg;

	eimu_sticky #(.W(ERR_W)) u_err (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.set_i (err_set),
		.clr_i (err_clr),
		.q_o   (err_q)
	);

	// error mask storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_mask_reg <= ERR_RST;
		end else begin
			err_mask_reg <= err_mask_next;
		end
	end

	// -----------------------------------------------------------------
	// interrupt line
	// -----------------------------------------------------------------
	logic [31:0] ev_gated;
	logic        ev_pending;
	logic        err_pending;
	logic        irq_reg;

	assign ev_gated    = stat_q & mask_reg & EVENT_BITS;
	assign ev_pending  = |ev_gated;
	assign err_pending = |(err_q & err_mask_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= ev_pending | err_pending;
		end
	end

	assign irq_o = irq_reg;

	// -----------------------------------------------------------------
	// read data
	// -----------------------------------------------------------------
	logic [31:0] stat_view;

	// status view carries the pending flag in bit 0
	assign stat_view = (stat_q & EVENT_BITS) | {31'h0000_0000, ev_pending};
	assign rif.rdata = hit_mask     ? mask_reg :
	                   hit_status   ? stat_view :
	                   hit_err_stat ? {{(32-ERR_W){1'b0}}, err_q} :
	                   hit_err_mask ? {{(32-ERR_W){1'b0}}, err_mask_reg} :
	                                  32'h0000_0000;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic quiet_others;
	assign quiet_others = ~err_pending;

	a_pto_gate: assert property (stat_q[BIT_PTO] && mask_reg[BIT_PTO] |=> irq_o)
		else $error("preamble timeout did not raise irq");
	a_pin_gate: assert property (stat_q[BIT_PIN] && !mask_reg[BIT_PIN] && quiet_others
		&& ((stat_q & mask_reg & EVENT_BITS) == 32'h0000_0000) |=> !irq_o)
		else $error("masked pin event raised irq");
	a_slp_gate: assert property (stat_q[BIT_SLP] && mask_reg[BIT_SLP] |-> ##1 irq_o)
		else $error("sleep to idle did not raise irq");
	a_rpll_gate: assert property ($rose(stat_q[BIT_RPLL] & mask_reg[BIT_RPLL])
		|-> ##1 irq_o)
		else $error("radio pll loss did not raise irq");
	a_cpll_gate: assert property (stat_q[BIT_CPLL] && mask_reg[BIT_CPLL] |=> irq_o)
		else $error("clock pll loss did not raise irq");
	a_sfd_gate: assert property (stat_q[BIT_SFDTO] && mask_reg[BIT_SFDTO] [*2]
		|=> irq_o [*1])
		else $error("delimiter timeout did not hold irq");
	a_hpw_gate: assert property (stat_q[BIT_HPW] && mask_reg[BIT_HPW] |=> irq_o)
		else $error("half period warning did not raise irq");
	a_txb_gate: assert property (stat_q[BIT_TX_BUFFER_ERROR_EVENT] && mask_reg[BIT_TX_BUFFER_ERROR_EVENT] |=> irq_o)
		else $error("tx buffer error did not raise irq");
	a_frej_gate: assert property (stat_q[BIT_FREJ] && mask_reg[BIT_FREJ] |=> irq_o)
		else $error("filter reject did not raise irq");
	a_rsvd_zero: assert property ((mask_reg & RSVD_BITS) == 32'h0000_0000)
		else $error("reserved mask bits stored");
	a_irq_level: assert property (irq_o == $past(ev_pending | err_pending))
		else $error("irq does not follow pending state");
	a_w1c_keep: assert property (rif.wr_stb && hit_status && stat_q[BIT_PTO]
		&& !rif.wdata[BIT_PTO] |=> stat_q[BIT_PTO])
		else $error("write zero cleared status");
	a_w1c_clear: assert property (rif.wr_stb && hit_status && rif.be[3]
		&& rif.wdata[BIT_FREJ] && !filter_reject_event_i |=> !stat_q[BIT_FREJ])
		else $error("write one did not clear status");
	a_ev_latch: assert property (tx_buffer_error_event_i |=> stat_q[BIT_TX_BUFFER_ERROR_EVENT])
		else $error("event not latched");
	a_mask_rst: assert property ($past(rst_i) |-> mask_reg == MASK_RST)
		else $error("mask not zero after reset");
	a_mask_wr: assert property (rif.wr_stb && hit_mask && (rif.be == 4'hf)
		|=> mask_reg == ($past(rif.wdata) & EVENT_BITS))
		else $error("mask write not stored");

	// level against a pending sum formed apart from the gating path
	a_irq_any: assert property ((stat_q & mask_reg & EVENT_BITS) != 32'h0000_0000
		|=> irq_o)
		else $error("enabled status bit left irq low");
	a_irq_quiet: assert property (((stat_q & mask_reg & EVENT_BITS) == 32'h0000_0000)
		&& !err_pending |=> !irq_o)
		else $error("irq high with nothing enabled");

	// byte lanes outside the request keep their bits
	a_w1c_lanes: assert property (rif.wr_stb && hit_status && !rif.be[2]
		&& stat_q[BIT_PTO] |=> stat_q[BIT_PTO])
		else $error("status bit cleared through a disabled lane");
	a_mask_lane: assert property (rif.wr_stb && hit_mask && !rif.be[3]
		|=> mask_reg[31:24] == $past(mask_reg[31:24]))
		else $error("mask lane written with its enable low");

	// error causes and bus answer
	a_rsvd_err: assert property (rif.wr_stb && hit_mask && rif.be[3]
		&& (rif.wdata[31:30] != 2'b00) |=> err_q[ERR_RSVD_WR])
		else $error("reserved mask write not flagged");
	a_err_unmap: assert property ((rif.wr_stb || rif.rd_stb) && unmapped
		|=> err_q[ERR_UNMAPPED])
		else $error("unmapped access not flagged");
	a_err_rd_clr: assert property (rif.rd_stb && hit_err_stat |=> err_q == ERR_RST)
		else $error("error cause survived its read");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held for more than one cycle");

	c_irq_rise: cover property ($rose(irq_o));
	c_irq_fall: cover property ($fell(irq_o));
	c_w1c: cover property (rif.wr_stb && hit_status && (ev_clr != 32'h0000_0000));
	c_err_read: cover property (rif.rd_stb && hit_err_stat && (err_q != ERR_RST));
	c_lane_wr: cover property (rif.wr_stb && (rif.be != 4'hf));
endmodule

/* File: rtl/eimu_wb_slave.sv */
/*
 * classic wishbone slave front end: one wait state, registered ack and data.
 * assumes the master holds the request until it samples ack.
 */
`timescale 1ns/10ps
module eimu_wb_slave
	import eimu_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// register core
	eimu_reg_if.bus          rif
);
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic        req;

	// a new request is taken once, in the cycle before ack
	assign req        = cyc_i & stb_i & ~ack_reg;
	assign rif.wr_stb = req & we_i;
	assign rif.rd_stb = req & ~we_i;
	assign rif.idx    = adr_i[7:2];
	assign rif.wdata  = dat_i;
	assign rif.be     = sel_i;

	// ack and read data capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			dat_reg <= rif.rd_stb ? rif.rdata : 32'h0000_0000;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;
endmodule

/* File: verification/eimu_host_model.sv */
/*
 * host side model: watches the interrupt request line and counts requests.
 * assumes irq_i is a registered level in the clk_i domain.
 */
`timescale 1ns/10ps
module eimu_host_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// interrupt request from the block
	input  wire logic        irq_i,
	// count of requests seen
	output logic      [15:0] edges_o
);
	logic irq_reg;

	// level seen by host
	// count each rise of the request line
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
			edges_o <= 16'h0000;
		end else begin
			irq_reg <= irq_i;
			if (irq_i && !irq_reg) begin
				edges_o <= edges_o + 16'h0001;
			end
		end
	end
endmodule

/* File: verification/eimu_top_bench.sv */
/*
 * self-checking bench for the upper event interrupt mask block.
 * assumes one wait state on the bus and registered irq as in the notes.
 */
`timescale 1ns/10ps
module eimu_top_bench import eimu_pkg::*;;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        irq_o;
	logic [8:0]  ev;
	logic [15:0] edges;
	logic [31:0] rd;
	int          mismatches;
	int          n_checks;

	// ---------------------------------------------------------------
	// design and host model
	// ---------------------------------------------------------------
	eimu_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
		.preamble_timeout_event_i(ev[0]), .pin_interrupt_event_i(ev[1]),
		.sleep_to_idle_event_i(ev[2]), .radio_pll_lock_loss_event_i(ev[3]),
		.clock_pll_lock_loss_event_i(ev[4]), .frame_delimiter_timeout_event_i(ev[5]),
		.half_period_warning_event_i(ev[6]), .tx_buffer_error_event_i(ev[7]),
		.filter_reject_event_i(ev[8]), .irq_o(irq_o));
	eimu_host_model host (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o), .edges_o(edges));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	// one-cycle event pulse on the chosen sources
	task automatic pulse(input logic [8:0] v);
		ev <= v;
		@(posedge clk_i);
		ev <= 9'h000;
		@(posedge clk_i);
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		wb(1'b0, 8'h38, 32'h0);
		check(rd, MASK_RST);
		wb(1'b0, 8'h3c, 32'h0);
		check(rd, STATUS_RST);
		check({31'h0, irq_o}, 32'h0);
		$display("reset values done");
	endtask

	task automatic t_mask_rw;
		wb(1'b1, 8'h38, 32'hffff_ffff);
		wb(1'b0, 8'h38, 32'h0);
		check(rd, EVENT_BITS);
		idle(2);
		check({31'h0, irq_o}, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0000_0002);
		wb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0);
		wb(1'b1, 8'h38, 32'h0);
		wb(1'b0, 8'h38, 32'h0);
		check(rd, 32'h0);
		$display("mask storage done");
	endtask

	// each source alone: masked, unmasked, cleared
	task automatic t_events;
		logic [31:0] b;
		for (int i = 0; i < 9; i++) begin
			b = 32'h1 << (BIT_PTO + i);
			pulse(9'(1 << i));
			idle(2);
			check({31'h0, irq_o}, 32'h0);
			wb(1'b0, 8'h3c, 32'h0);
			check(rd, b);
			wb(1'b1, 8'h38, b);
			idle(1);
			check({31'h0, irq_o}, 32'h1);
			wb(1'b0, 8'h3c, 32'h0);
			check(rd, b | 32'h1);
			wb(1'b1, 8'h3c, b);
			idle(1);
			check({31'h0, irq_o}, 32'h0);
			wb(1'b1, 8'h38, 32'h0);
		end
		check({16'h0, edges}, 32'h9);
		$display("per event gating done");
	endtask

	// write zero keeps, clearing one of two keeps the line up
	task automatic t_keep;
		pulse(9'h003);
		wb(1'b1, 8'h38, 32'h0060_0000);
		wb(1'b1, 8'h3c, 32'h0);
		wb(1'b0, 8'h3c, 32'h0);
		check(rd, 32'h0060_0001);
		wb(1'b1, 8'h3c, 32'h0020_0000);
		idle(1);
		check({31'h0, irq_o}, 32'h1);
		wb(1'b1, 8'h3c, 32'h0040_0000);
		idle(1);
		check({31'h0, irq_o}, 32'h0);
		wb(1'b1, 8'h38, 32'h0);
		$display("sticky status done");
	endtask

	// unmapped access raises the error cause, read clears it
	task automatic t_err;
		wb(1'b1, 8'h44, 32'h1);
		wb(1'b0, 8'h7c, 32'h0);
		check(rd, 32'h0);
		idle(1);
		check({31'h0, irq_o}, 32'h1);
		wb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h1);
		idle(1);
		check({31'h0, irq_o}, 32'h0);
		wb(1'b1, 8'h44, 32'h0);
		$display("error cause done");
	endtask

	// partial byte lanes on mask write, status clear and error mask
	task automatic t_lanes;
		sel <= 4'h4;
		wb(1'b1, 8'h38, 32'hffff_ffff);
		sel <= 4'hf;
		wb(1'b0, 8'h38, 32'h0);
		check(rd, 32'h00e0_0000);
		pulse(9'h101);
		sel <= 4'h8;
		wb(1'b1, 8'h3c, 32'hffff_ffff);
		sel <= 4'h2;
		wb(1'b1, 8'h44, 32'h0000_0003);
		sel <= 4'hf;
		wb(1'b0, 8'h3c, 32'h0);
		check(rd, 32'h0020_0001);
		wb(1'b0, 8'h44, 32'h0);
		check(rd, 32'h0);
		check({31'h0, irq_o}, 32'h1);
		wb(1'b1, 8'h3c, 32'h0020_0000);
		wb(1'b1, 8'h38, 32'h0);
		$display("byte lanes done");
	endtask

	// ---------------------------------------------------------------
	// clock, run control
	// ---------------------------------------------------------------
	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// watchdog well beyond the few hundred cycles needed
	initial begin
		#(40 * 5000);
		mismatches++;
		complete_run;
	end

	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hf;
		wdat = 32'h0;
		ev = 9'h000;
		mismatches = 0;
		n_checks = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_mask_rw;
		t_events;
		t_keep;
		t_err;
		t_lanes;
		complete_run;
	end
endmodule
